/* crmb_rx_filter.sv */
// AXI4-Lite register block with filter 8-15 acceptance and buffer flags.
//
// Decided for this implementation: the register addresses and the AXI4-Lite slave port.
module crmb_rx_filter (
  input  wire logic                          clock,
  input  wire logic                          sys_rst,
  input  wire logic [crmb_pkg::ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic [2:0]                    s_axi_awprot,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [crmb_pkg::DATA_W-1:0]   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  input  wire logic [crmb_pkg::ADDR_W-1:0]   s_axi_araddr,
  input  wire logic [2:0]                    s_axi_arprot,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [crmb_pkg::DATA_W-1:0]        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  input  wire logic                          msg_valid,
  input  wire logic                          msg_extended,
  input  wire logic [10:0]                   msg_sid,
  input  wire logic [17:0]                   msg_eid,
  input  wire logic [4:0]                    fifo_slot,
  output logic                               rx_accept,
  output logic [3:0]                         rx_filter,
  output logic [4:0]                         rx_buffer,
  output logic                               rx_overflow
);
  import crmb_pkg::*;

  // Byte-lane merge of a write into a 16-bit register.
  function automatic logic [REG_W-1:0] wmerge(
    input logic [REG_W-1:0]  old,
    input logic [DATA_W-1:0] data,
    input logic [3:0]        strb
  );
    return {strb[1] ? data[15:8] : old[15:8],
            strb[0] ? data[7:0]  : old[7:0]};
  endfunction

  // Bits kept by a write-zero-to-clear access; unselected lanes keep all.
  function automatic logic [REG_W-1:0] wkeep(
    input logic [DATA_W-1:0] data,
    input logic [3:0]        strb
  );
    return {strb[1] ? data[15:8] : 8'hFF,
            strb[0] ? data[7:0]  : 8'hFF};
  endfunction

  function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
    logic [ADDR_W-1:0] w;
    w = {addr[ADDR_W-1:2], 2'b00};
    return (w <= OFF_FILT_EN) || (w >= OFF_FILT_STD0 &&
           w < OFF_FILT_EXT0 + 8'(NUM_FILT * 4));
  endfunction

  logic [REG_W-1:0]                 mask_sel;
  logic [REG_W-1:0]                 next_mask_sel;
  logic [2:0][REG_W-1:0]            mask_std;
  logic [2:0][REG_W-1:0]            next_mask_std;
  logic [2:0][REG_W-1:0]            mask_ext;
  logic [2:0][REG_W-1:0]            next_mask_ext;
  logic [NUM_FILT-1:0][REG_W-1:0]   filt_std;
  logic [NUM_FILT-1:0][REG_W-1:0]   next_filt_std;
  logic [NUM_FILT-1:0][REG_W-1:0]   filt_ext;
  logic [NUM_FILT-1:0][REG_W-1:0]   next_filt_ext;
  logic [2*REG_W-1:0]               buf_ptr;
  logic [2*REG_W-1:0]               next_buf_ptr;
  logic [NUM_FILT-1:0]              filt_en;
  logic [NUM_FILT-1:0]              next_filt_en;
  logic [NUM_BUF-1:0]               full;
  logic [NUM_BUF-1:0]               next_full;
  logic [NUM_BUF-1:0]               ovf;
  logic [NUM_BUF-1:0]               next_ovf;

  logic                aw_held;
  logic                next_aw_held;
  logic [ADDR_W-1:0]   aw_addr;
  logic [ADDR_W-1:0]   next_aw_addr;
  logic                w_held;
  logic                next_w_held;
  logic [DATA_W-1:0]   w_data;
  logic [DATA_W-1:0]   next_w_data;
  logic [3:0]          w_strb;
  logic [3:0]          next_w_strb;
  logic                next_bvalid;
  logic [1:0]          next_bresp;
  logic                next_rvalid;
  logic [DATA_W-1:0]   next_rdata;
  logic [1:0]          next_rresp;
  logic [REG_W-1:0]    rd_val;
  logic                do_write;
  logic [ADDR_W-1:0]   wr_word;
  logic [ADDR_W-1:0]   rd_word;

  logic [NUM_FILT-1:0] hits;
  logic [2:0]          sel;
  logic [3:0]          ptr;
  logic [4:0]          idx;
  logic                store;
  logic                next_rx_accept;
  logic [3:0]          next_rx_filter;
  logic [4:0]          next_rx_buffer;
  logic                next_rx_overflow;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write      = aw_held && w_held && !s_axi_bvalid;
  assign wr_word       = {aw_addr[ADDR_W-1:2], 2'b00};
  assign rd_word       = {s_axi_araddr[ADDR_W-1:2], 2'b00};

  genvar g;
  generate
    for (g = 0; g < NUM_FILT; g++) begin : gen_filt
      logic raw_hit;
      crmb_filter_match u_match (
        .filter_std   (filt_std[g]),
        .filter_ext   (filt_ext[g]),
        .mask_source  (mask_sel[2*g+1:2*g]),
        .mask_std_all (mask_std),
        .mask_ext_all (mask_ext),
        .msg_extended (msg_extended),
        .msg_sid      (msg_sid),
        .msg_eid      (msg_eid),
        .hit          (raw_hit)
      );
      assign hits[g] = raw_hit && filt_en[g];
    end
  endgenerate

  // The lowest-numbered filter that hits decides where the message goes.
  always_comb begin
    sel = 3'h0;
    for (int k = NUM_FILT - 1; k >= 0; k--) begin
      if (hits[k]) begin
        sel = 3'(k);
      end
    end
    ptr   = buf_ptr[4*sel +: 4];
    idx   = (ptr == FIFO_PTR) ? fifo_slot : {1'b0, ptr};
    store = msg_valid && (hits != 8'h00);
  end

  always_comb begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held  = w_held;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = s_axi_bvalid;
    next_bresp   = s_axi_bresp;
    next_rvalid  = s_axi_rvalid;
    next_rdata   = s_axi_rdata;
    next_rresp   = s_axi_rresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = is_mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rdata  = {16'h0000, rd_val};
      next_rresp  = is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  always_comb begin
    rd_val = RST_REG;
    if (rd_word == OFF_MASK_SEL) rd_val = mask_sel;
    if (rd_word == OFF_FULL_LO) rd_val = full[15:0];
    if (rd_word == OFF_FULL_HI) rd_val = full[31:16];
    if (rd_word == OFF_OVF_LO) rd_val = ovf[15:0];
    if (rd_word == OFF_OVF_HI) rd_val = ovf[31:16];
    if (rd_word == OFF_BUF_PTR_LO) rd_val = buf_ptr[15:0];
    if (rd_word == OFF_BUF_PTR_HI) rd_val = buf_ptr[31:16];
    if (rd_word == OFF_FILT_EN) rd_val = {8'h00, filt_en};
    for (int n = 0; n < NUM_MASK; n++) begin
      if (rd_word == OFF_MASK_STD0 + 8'(4 * n)) rd_val = mask_std[n];
      if (rd_word == OFF_MASK_EXT0 + 8'(4 * n)) rd_val = mask_ext[n];
    end
    for (int k = 0; k < NUM_FILT; k++) begin
      if (rd_word == OFF_FILT_STD0 + 8'(4 * k)) rd_val = filt_std[k];
      if (rd_word == OFF_FILT_EXT0 + 8'(4 * k)) rd_val = filt_ext[k];
    end
  end

  always_comb begin
    next_mask_sel = mask_sel;
    next_mask_std = mask_std;
    next_mask_ext = mask_ext;
    next_filt_std = filt_std;
    next_filt_ext = filt_ext;
    next_buf_ptr  = buf_ptr;
    next_filt_en  = filt_en;
    if (do_write) begin
      if (wr_word == OFF_MASK_SEL)
        next_mask_sel = wmerge(mask_sel, w_data, w_strb);
      if (wr_word == OFF_BUF_PTR_LO)
        next_buf_ptr[15:0] = wmerge(buf_ptr[15:0], w_data, w_strb);
      if (wr_word == OFF_BUF_PTR_HI)
        next_buf_ptr[31:16] = wmerge(buf_ptr[31:16], w_data, w_strb);
      if (wr_word == OFF_FILT_EN && w_strb[0])
        next_filt_en = w_data[7:0];
      for (int n = 0; n < NUM_MASK; n++) begin
        if (wr_word == OFF_MASK_STD0 + 8'(4 * n))
          next_mask_std[n] = wmerge(mask_std[n], w_data, w_strb) & STD_IMPL;
        if (wr_word == OFF_MASK_EXT0 + 8'(4 * n))
          next_mask_ext[n] = wmerge(mask_ext[n], w_data, w_strb);
      end
      for (int k = 0; k < NUM_FILT; k++) begin
        if (wr_word == OFF_FILT_STD0 + 8'(4 * k))
          next_filt_std[k] = wmerge(filt_std[k], w_data, w_strb) & STD_IMPL;
        if (wr_word == OFF_FILT_EXT0 + 8'(4 * k))
          next_filt_ext[k] = wmerge(filt_ext[k], w_data, w_strb);
      end
    end
  end

  // Flags: software clears with zeros, a store in the same cycle still sets.
  always_comb begin
    logic [NUM_BUF-1:0] keep_full;
    logic [NUM_BUF-1:0] keep_ovf;
    keep_full = {NUM_BUF{1'b1}};
    keep_ovf  = {NUM_BUF{1'b1}};
    if (do_write) begin
      if (wr_word == OFF_FULL_LO) keep_full[15:0] = wkeep(w_data, w_strb);
      if (wr_word == OFF_FULL_HI) keep_full[31:16] = wkeep(w_data, w_strb);
      if (wr_word == OFF_OVF_LO) keep_ovf[15:0] = wkeep(w_data, w_strb);
      if (wr_word == OFF_OVF_HI) keep_ovf[31:16] = wkeep(w_data, w_strb);
    end
    next_full = full & keep_full;
    next_ovf  = ovf & keep_ovf;
    if (store && full[idx]) begin
      next_ovf[idx] = 1'b1;
    end else if (store) begin
      next_full[idx] = 1'b1;
    end
    next_rx_accept   = store;
    next_rx_filter   = 4'(FIRST_FILT) + {1'b0, sel};
    next_rx_buffer   = store ? idx : rx_buffer;
    next_rx_overflow = store && full[idx];
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      aw_held      <= 1'b0;
      aw_addr      <= 8'h00;
      w_held       <= 1'b0;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else begin
      aw_held      <= next_aw_held;
      aw_addr      <= next_aw_addr;
      w_held       <= next_w_held;
      w_data       <= next_w_data;
      w_strb       <= next_w_strb;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp  <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= next_rresp;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      mask_sel <= RST_REG;
      mask_std <= '0;
      mask_ext <= '0;
      filt_std <= '0;
      filt_ext <= '0;
      buf_ptr  <= 32'h0000_0000;
      filt_en  <= RST_EN;
    end else begin
      mask_sel <= next_mask_sel;
      mask_std <= next_mask_std;
      mask_ext <= next_mask_ext;
      filt_std <= next_filt_std;
      filt_ext <= next_filt_ext;
      buf_ptr  <= next_buf_ptr;
      filt_en  <= next_filt_en;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      full        <= RST_FLAGS;
      ovf         <= RST_FLAGS;
      rx_accept   <= 1'b0;
      rx_filter   <= 4'h0;
      rx_buffer   <= 5'h00;
      rx_overflow <= 1'b0;
    end else begin
      full        <= next_full;
      ovf         <= next_ovf;
      rx_accept   <= next_rx_accept;
      rx_filter   <= next_rx_filter;
      rx_buffer   <= next_rx_buffer;
      rx_overflow <= next_rx_overflow;
    end
  end
endmodule

/* crmb_pkg.sv */
// Constants and types shared by the CAN receive mask and buffer flag block.
// Functional notes
// - Each filter's two-bit mask source picks mask set 0, 1 or 2 for codes 00, 01, 10, and code 11 uses no mask.
// - The high mask select register holds eight two-bit fields, filter 15 in bits 15-14 down to filter 8 in bits 1-0.
// - A standard identifier mask bit of one includes that identifier bit in the comparison, zero makes it don't-care.
// - The two upper extended bits in the standard mask word and sixteen in the extended mask word include or exclude their extended identifier bits.
// - With the mask's identifier type bit at one, a filter accepts only messages whose format equals its extended select bit.
// - With the mask's identifier type bit at zero, standard and extended messages are both accepted when the masked bits agree.
// - The two unimplemented positions, bits 4 and 2, of each standard mask register always read as zero.
// - The block sets a buffer's full flag when it places a message there, and a clear flag means the buffer is empty.
// - The block sets a buffer's overflow flag when it tries to store into a buffer whose full flag is already set.
// - Full and overflow flags are readable and are cleared only by writing zero, a one leaves them unchanged.
// - An included identifier bit matches only when the message bit equals the filter bit.
// - A filter's extended select bit of one picks extended messages and zero picks standard ones when the type check applies.
// - Each filter's four-bit buffer pointer sends an accepted message to buffer 0 to 14, or to the receive FIFO when all ones.
package crmb_pkg;
  localparam int ADDR_W     = 8;
  localparam int DATA_W     = 32;
  localparam int REG_W      = 16;
  localparam int NUM_FILT   = 8;
  localparam int FIRST_FILT = 8;
  localparam int NUM_MASK   = 3;
  localparam int NUM_BUF    = 32;

  localparam logic [ADDR_W-1:0] OFF_MASK_SEL   = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_MASK_STD0  = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_MASK_EXT0  = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_FULL_LO    = 8'h1C;
  localparam logic [ADDR_W-1:0] OFF_FULL_HI    = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_OVF_LO     = 8'h24;
  localparam logic [ADDR_W-1:0] OFF_OVF_HI     = 8'h28;
  localparam logic [ADDR_W-1:0] OFF_BUF_PTR_LO = 8'h2C;
  localparam logic [ADDR_W-1:0] OFF_BUF_PTR_HI = 8'h30;
  localparam logic [ADDR_W-1:0] OFF_FILT_EN    = 8'h34;
  localparam logic [ADDR_W-1:0] OFF_FILT_STD0  = 8'h40;
  localparam logic [ADDR_W-1:0] OFF_FILT_EXT0  = 8'h60;
  localparam logic [ADDR_W-1:0] REG_STRIDE     = 8'h04;

  localparam int SID_HI    = 15;
  localparam int SID_LO    = 5;
  localparam int TYPE_BIT  = 3;
  localparam int EID_TOP_W = 2;

  localparam logic [REG_W-1:0]   STD_IMPL   = 16'hFFEB;
  localparam logic [REG_W-1:0]   ALL_ONES   = 16'hFFFF;
  localparam logic [REG_W-1:0]   RST_REG    = 16'h0000;
  localparam logic [NUM_BUF-1:0] RST_FLAGS  = 32'h0000_0000;
  localparam logic [7:0]         RST_EN     = 8'h00;
  localparam logic [3:0]         FIFO_PTR   = 4'hF;
  localparam logic [1:0]         RESP_OKAY  = 2'h0;
  localparam logic [1:0]         RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    MASK_SET0,
    MASK_SET1,
    MASK_SET2,
    MASK_NONE
  } crmb_mask_src_t;
endpackage

/* crmb_filter_match.sv */
// Acceptance comparison of one filter against one received identifier.
module crmb_filter_match (
  input  wire logic [crmb_pkg::REG_W-1:0]         filter_std,
  input  wire logic [crmb_pkg::REG_W-1:0]         filter_ext,
  input  wire logic [1:0]                         mask_source,
  input  wire logic [2:0][crmb_pkg::REG_W-1:0]    mask_std_all,
  input  wire logic [2:0][crmb_pkg::REG_W-1:0]    mask_ext_all,
  input  wire logic                               msg_extended,
  input  wire logic [10:0]                        msg_sid,
  input  wire logic [17:0]                        msg_eid,
  output logic                                    hit
);
  import crmb_pkg::*;

  logic [REG_W-1:0] msk_std;
  logic [REG_W-1:0] msk_ext;
  logic [10:0]      sid_diff;
  logic [17:0]      eid_diff;
  logic             type_ok;

  always_comb begin
    unique case (crmb_mask_src_t'(mask_source))
      MASK_SET0: begin
        msk_std = mask_std_all[0];
        msk_ext = mask_ext_all[0];
      end
      MASK_SET1: begin
        msk_std = mask_std_all[1];
        msk_ext = mask_ext_all[1];
      end
      MASK_SET2: begin
        msk_std = mask_std_all[2];
        msk_ext = mask_ext_all[2];
      end
      MASK_NONE: begin
        msk_std = STD_IMPL;
        msk_ext = ALL_ONES;
      end
    endcase
  end

  always_comb begin
    sid_diff = msk_std[SID_HI:SID_LO] & (filter_std[SID_HI:SID_LO] ^ msg_sid);
    eid_diff = {msk_std[EID_TOP_W-1:0], msk_ext} &
               ({filter_std[EID_TOP_W-1:0], filter_ext} ^ msg_eid);
    type_ok  = !msk_std[TYPE_BIT] || (filter_std[TYPE_BIT] == msg_extended);
    // Standard frames carry no extended bits, so only their STANDARD_IDENTIFIER_BITS is compared.
    hit      = type_ok && (sid_diff == 11'h000) &&
               (!msg_extended || (eid_diff == 18'h0_0000));
  end
endmodule

/* crmb_monitor.sv */
// Checker for handshake and receive-event timing at the block's ports.
module crmb_monitor (
  input wire logic        clock,
  input wire logic        sys_rst,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        msg_valid,
  input wire logic        rx_accept,
  input wire logic [3:0]  rx_filter,
  input wire logic        rx_overflow
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  a_accept_cause: assert property (
    rx_accept |-> $past(msg_valid)) else $error("accept without a frame");
  a_ovf_accept: assert property (
    rx_overflow |-> rx_accept) else $error("overflow without accept");
  a_filter_range: assert property (
    rx_accept |-> rx_filter[3]) else $error("winning filter below 8");
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> ##1 s_axi_bvalid) else $error("write response late");
  a_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_rdata_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_upper_zero: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read bits set");
  a_busy_refuse: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answering");

  c_overflow: cover property (rx_overflow);
  c_top_filter: cover property (rx_accept && rx_filter == 4'hF);
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
  c_resp_wait: cover property (s_axi_bvalid && !s_axi_bready);
endmodule

bind crmb_rx_filter crmb_monitor mon (.clock, .sys_rst, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .msg_valid, .rx_accept, .rx_filter,
  .rx_overflow);

/* crmb_can_node.sv */
// Model of a remote node handing received frames to the block.
module crmb_can_node (
  input  wire logic        clock,
  output logic             msg_valid,
  output logic             msg_extended,
  output logic [10:0]      msg_sid,
  output logic [17:0]      msg_eid
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    msg_valid = 1'b0;
    msg_extended = 1'b0;
    msg_sid = 11'h000;
    msg_eid = 18'h0_0000;
  end

  // Outside a frame the identifier lines show inverted junk, not the last id.
  task automatic send(input logic e, input logic [10:0] s,
                      input logic [17:0] x);
    @(posedge clock);
    msg_valid <= 1'b1;
    msg_extended <= e;
    msg_sid <= s;
    msg_eid <= x;
    @(posedge clock);
    msg_valid <= 1'b0;
    msg_extended <= ~e;
    msg_sid <= ~s;
    msg_eid <= ~x;
  endtask
endmodule

/* test_can_rx_mask_and_buffer_flags.sv */
// Self-checking testbench for the receive mask and buffer flag block.
module test_can_rx_mask_and_buffer_flags;
  timeunit 1ns;
  timeprecision 100ps;
  import crmb_pkg::*;
  typedef struct packed {
    logic [1:0]  code;
    logic [15:0] mstd;
    logic [15:0] mext;
    logic [15:0] fstd;
    logic [15:0] fext;
    logic        ext;
    logic [10:0] standard_identifier_bits;
    logic [17:0] extended_identifier_bits;
    logic        acc;
  } crmb_row_t;
  crmb_row_t rows [10] = '{
    '{2'h0,16'hFFE8,16'h0000,16'h2460,16'h0000,
      1'b0,11'h123,18'h0_0000,1'b1},
    '{2'h0,16'hFFE8,16'h0000,16'h2460,16'h0000,
      1'b0,11'h122,18'h0_0000,1'b0},
    '{2'h1,16'hFFC0,16'h0000,16'h2460,16'h0000,
      1'b0,11'h122,18'h0_0000,1'b1},
    '{2'h2,16'hFFE8,16'h0000,16'h2460,16'h0000,
      1'b1,11'h123,18'h0_0000,1'b0},
    '{2'h2,16'hFFE0,16'h0000,16'h2460,16'h0000,
      1'b1,11'h123,18'h0_0ABC,1'b1},
    '{2'h0,16'hFFEB,16'hFFFF,16'h246A,16'h1234,
      1'b1,11'h123,18'h2_1234,1'b1},
    '{2'h0,16'hFFEB,16'hFFFF,16'h246A,16'h1234,
      1'b1,11'h123,18'h2_1235,1'b0},
    '{2'h0,16'hFFEB,16'hFFFE,16'h246A,16'h1234,
      1'b1,11'h123,18'h2_1235,1'b1},
    '{2'h3,16'h0000,16'h0000,16'h2460,16'h0000,
      1'b0,11'h122,18'h0_0000,1'b0},
    '{2'h3,16'h0000,16'h0000,16'h2460,16'h0000,
      1'b0,11'h123,18'h0_0000,1'b1}};
  logic [7:0] zero_regs [5] = '{OFF_MASK_SEL, OFF_FULL_LO, OFF_FULL_HI,
                                OFF_OVF_LO, OFF_OVF_HI};
  logic        clock = 1'b0;
  logic        sys_rst = 1'b1;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic [4:0]  fifo_slot = 5'h14;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, rx_accept, rx_overflow;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata;
  logic        msg_valid, msg_extended;
  logic [10:0] msg_sid;
  logic [17:0] msg_eid;
  logic [4:0]  rx_buffer;
  logic [3:0]  rx_filter;
  logic [15:0] rd, full_exp;
  int          failures = 0;
  int          n_tests = 0;
  int          cycles = 0;
  int          lag = 0;

  always #12.5 clock = ~clock;

  crmb_rx_filter dut (.clock, .sys_rst, .s_axi_awaddr, .s_axi_awprot(3'h0),
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF),
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .msg_valid,
    .msg_extended, .msg_sid, .msg_eid, .fifo_slot, .rx_accept, .rx_filter,
    .rx_buffer, .rx_overflow);
  crmb_can_node node (.clock, .msg_valid, .msg_extended, .msg_sid, .msg_eid);

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // A nonzero lag holds the response ready low for that many cycles.
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    int n;
    n = lag;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= (n == 0);
    do begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (n > 0) begin
        n--;
        if (n == 0) s_axi_bready <= 1'b1;
      end
    end while (!(s_axi_bvalid && s_axi_bready));
    s_axi_bready <= 1'b0;
    resp = s_axi_bresp;
  endtask

  task automatic rd_reg(input logic [7:0] a);
    int n;
    n = lag;
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= (n == 0);
    do begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (n > 0) begin
        n--;
        if (n == 0) s_axi_rready <= 1'b1;
      end
    end while (!(s_axi_rvalid && s_axi_rready));
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata[15:0];
    resp = s_axi_rresp;
  endtask

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      failures++;
      give_verdict();
    end
  end

  initial begin
    full_exp = 16'h0000;
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    wr(OFF_FILT_EN, 16'h0001);
    foreach (rows[i]) begin
      wr(OFF_MASK_SEL, {14'h0000, rows[i].code});
      if (rows[i].code != 2'h3) begin
        wr(OFF_MASK_STD0 + 8'(4 * rows[i].code), rows[i].mstd);
        wr(OFF_MASK_EXT0 + 8'(4 * rows[i].code), rows[i].mext);
      end
      wr(OFF_FILT_STD0, rows[i].fstd);
      wr(OFF_FILT_EXT0, rows[i].fext);
      wr(OFF_BUF_PTR_LO, 16'(i));
      node.send(rows[i].ext, rows[i].standard_identifier_bits, rows[i].extended_identifier_bits);
      #1;
      check(rx_accept, rows[i].acc);
      if (rows[i].acc) begin
        check(rx_buffer, 5'(i));
        full_exp[i] = 1'b1;
      end
      $display("row %0d done", i);
    end
    rd_reg(OFF_FULL_LO);
    check(rd, full_exp);
    $display("table done");
    @(posedge clock);
    sys_rst <= 1'b1;
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    foreach (zero_regs[i]) begin
      rd_reg(zero_regs[i]);
      check(rd, 16'h0000);
    end
    $display("reset test done");
    wr(OFF_MASK_STD0 + 8'h04, 16'hFFFF);
    rd_reg(OFF_MASK_STD0 + 8'h04);
    check(rd, 16'hFFEB);
    $display("unimplemented bits test done");
    wr(OFF_FILT_EN, 16'h0080);
    wr(OFF_MASK_SEL, 16'h3FFF);
    wr(OFF_BUF_PTR_HI, 16'hF000);
    node.send(1'b0, 11'h555, 18'h0_0000);
    #1;
    check(rx_filter, 4'hF);
    check(rx_buffer, 5'h14);
    node.send(1'b0, 11'h555, 18'h0_0000);
    #1;
    check(rx_overflow, 1'b1);
    wr(OFF_MASK_SEL, 16'hC000);
    node.send(1'b0, 11'h555, 18'h0_0000);
    #1;
    check(rx_accept, 1'b0);
    rd_reg(OFF_OVF_HI);
    check(rd, 16'h0010);
    lag = 3;
    wr(OFF_FULL_HI, 16'hFFFF);
    rd_reg(OFF_FULL_HI);
    lag = 0;
    check(rd, 16'h0010);
    wr(OFF_FULL_HI, 16'hFFEF);
    rd_reg(OFF_FULL_HI);
    check(rd, 16'h0000);
    wr(OFF_OVF_HI, 16'h0000);
    rd_reg(OFF_OVF_HI);
    check(rd, 16'h0000);
    $display("flag test done");
    wr(8'hFC, 16'h1234);
    check(resp, 2'h2);
    rd_reg(8'hFC);
    check(resp, 2'h2);
    $display("unmapped test done");
    give_verdict();
  end
endmodule
